/* mct_edge.sv */
// edge detector for a synchronous input with separate rise and fall outputs
// assumes the input is already synchronous to the clock
`timescale 1ns/1ps
module mct_edge
   import mct_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sig_i,
   output logic rise_o,
   output logic fall_o
);
   logic last_reg;
   // hold previous sample
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_reg <= 1'b0;
      end else begin
         last_reg <= sig_i;
      end
   end
   // one-cycle edge pulses
   assign rise_o = sig_i & ~last_reg;
   assign fall_o = ~sig_i & last_reg;
endmodule // mct_edge

/* mct_pins_model.sv */
// far-side pins: drives capture and count inputs, watches match outputs
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ps
module mct_pins_model
   import mct_pkg::*;
(
   input wire logic clk_i,
   input wire logic [NUM_MATCH-1:0] match_i,
   output logic capture_o,
   output logic count_o
);
   int tog [NUM_MATCH];
   int high [NUM_MATCH];
   // pins idle low
   initial begin
      capture_o = 1'b0;
      count_o = 1'b0;
   end
   // one capture pulse, high for w edges
   task automatic pulse(input int w);
      capture_o <= 1'b1;
      repeat (w) @(posedge clk_i);
      capture_o <= 1'b0;
   endtask
   // n count pulses, two cycles high then two low
   task automatic count_pulses(input int n);
      repeat (n) begin
         count_o <= 1'b1;
         repeat (2) @(posedge clk_i);
         count_o <= 1'b0;
         repeat (2) @(posedge clk_i);
      end
   endtask
   // toggles and high cycles of each match pin over n edges
   task automatic measure(input int n);
      logic [NUM_MATCH-1:0] last;
      #1 last = match_i;
      for (int i = 0; i < NUM_MATCH; i++) begin
         tog[i] = 0;
         high[i] = 0;
      end
      repeat (n) begin
         @(posedge clk_i);
         for (int i = 0; i < NUM_MATCH; i++) begin
            tog[i] += int'(match_i[i] !== last[i]);
            high[i] += int'(match_i[i] === 1'b1);
         end
         last = match_i;
      end
   endtask
endmodule // mct_pins_model

/* mct_pkg.sv */
// package: constants, register map and carrier types for the counter/timer
// assumes one 125 MHz clock and the plain strobe register port
package mct_pkg;
   localparam int CNT_W = 32;
   localparam int NUM_MATCH = 4;
   localparam int ADDR_W = 8;
   localparam real CLOCK_MHZ = 125.0;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_PRESCALE = 8'h08;
   localparam logic [7:0] OFS_PRECOUNT = 8'h0C;
   localparam logic [7:0] OFS_MATCH_CTRL = 8'h10;
   localparam logic [7:0] OFS_CAPT_CTRL = 8'h14;
   localparam logic [7:0] OFS_CAPTURE = 8'h18;
   localparam logic [7:0] OFS_EXT_MATCH = 8'h1C;
   localparam logic [7:0] OFS_MODE = 8'h20;
   localparam logic [7:0] OFS_PWM_CTRL = 8'h24;
   localparam logic [7:0] OFS_FLAGS = 8'h28;
   localparam logic [7:0] OFS_MATCH0 = 8'h30;
   // control bits
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_RST_BIT = 1;
   // mode field: 0 timer, 1 rise, 2 fall, 3 both edges of count input
   localparam logic [1:0] MODE_TIMER = 2'h0;
   // edge codes for capture selection
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // external match actions
   localparam logic [1:0] EM_NONE = 2'h0;
   localparam logic [1:0] EM_LOW = 2'h1;
   localparam logic [1:0] EM_HIGH = 2'h2;
   localparam logic [1:0] EM_TOGGLE = 2'h3;
   // reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [3:0] FLAG_BITS = 4'h0;
   localparam logic [31:0] RST_MATCH = 32'hFFFF_FFFF;
   // per-match control: interrupt, reset, stop
   typedef struct packed {
      logic stop;
      logic reset;
      logic irq;
   } match_ctrl_t;
   // capture control
   typedef struct packed {
      logic clr_en;
      logic [1:0] clr_edge;
      logic irq;
      logic [1:0] cap_edge;
   } capt_ctrl_t;
   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } reg_req_t;
endpackage

/* mct_pwm.sv */
// pwm output stage: per-output level driven by duty match and period
// assumes match pulses are single-cycle and aligned with the count
`timescale 1ns/1ps
module mct_pwm
   import mct_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [NUM_MATCH-1:0] enable_i,
   input wire logic [NUM_MATCH-1:0] duty_hit_i,
   input wire logic period_hit_i,
   input wire logic [NUM_MATCH-1:0] ext_in_i,
   output logic [NUM_MATCH-1:0] out_o
);
   logic [NUM_MATCH-1:0] lvl_reg;
   // low until duty match, high until period end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lvl_reg <= 4'h0;
      end else begin
         for (int i = 0; i < NUM_MATCH; i++) begin
            if (period_hit_i) begin
               lvl_reg[i] <= 1'b0;
            end else if (duty_hit_i[i]) begin
               lvl_reg[i] <= 1'b1;
            end
         end
      end
   end
   // pwm outputs replace the external-match level when enabled
   assign out_o = (enable_i & lvl_reg) | (~enable_i & ext_in_i);
endmodule // mct_pwm

/* mct_timer.sv */
// match/capture counter/timer with prescaler, four matches, one capture
// assumes synchronous pins and a single-cycle strobe register port
// How it works
// - a 32-bit counter (16-bit via WIDTH_16) follows a same-width prescaler.
// - timer mode counts clock cycles, counter mode counts input edges.
// - four match registers compare against the count on each counter advance.
// - a match without stop or reset lets counting go on, flag if enabled.
// - stop on match halts counter and prescaler, flag optional.
// - reset on match zeroes the counter which keeps counting, flag optional.
// - each match output goes low, high, toggles or holds on its match.
// - the capture input edge copies the count into the capture register.
// - a chosen capture edge can clear the counter and the prescaler.
// - pwm mode makes the matches a shared period and per-output duty.
// - match outputs and capture input are exported as converter triggers.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module mct_timer
   import mct_pkg::*;
#(
   parameter bit WIDTH_16 = 1'b0
)
(
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   input wire logic COUNT_IN_I,
   input wire logic CAPTURE_IN_I,
   output logic [NUM_MATCH-1:0] MATCH_OUT_O,
   output logic [NUM_MATCH-1:0] MATCH_IRQ_O,
   output logic CAPTURE_IRQ_O,
   output logic [NUM_MATCH-1:0] ADC_MATCH_TRIG_O,
   output logic ADC_CAPTURE_TRIG_O
);
   ////////////////////////////////////////////////////////////////////////
   // declarations
   reg_req_t req;
   logic [31:0] width_mask;
   logic ctrl_en_reg, ctrl_rst_reg;
   logic [31:0] count_reg, count_next;
   logic [31:0] prescale_reg, precount_reg, precount_next;
   logic [31:0] capture_reg;
   logic [31:0] match_reg [NUM_MATCH];
   match_ctrl_t mctl_reg [NUM_MATCH];
   capt_ctrl_t cctl_reg;
   logic [1:0] em_act_reg [NUM_MATCH];
   logic [NUM_MATCH-1:0] em_lvl_reg;
   logic [1:0] mode_reg;
   logic [NUM_MATCH-1:0] pwm_en_reg;
   logic [1:0] period_sel_reg;
   logic [NUM_MATCH-1:0] mflag_reg;
   logic cflag_reg;
   logic [31:0] rdata_reg;
   logic cnt_rise, cnt_fall, cap_rise, cap_fall;
   logic tick, advance, wrap, cap_evt, clr_evt;
   logic [NUM_MATCH-1:0] hit, stop_hit, rst_hit;
   logic pwm_mode;

   assign req = '{wr: WR_I, rd: RD_I, addr: ADDR_I, wdata: WDATA_I};
   assign width_mask = WIDTH_16 ? 32'h0000_FFFF : 32'hFFFF_FFFF;

   // edge selection shared by counting and capture
   function automatic logic edge_sel(input logic [1:0] sel,
                                     input logic r, input logic f);
      case (sel)
         EDGE_RISE: edge_sel = r;
         EDGE_FALL: edge_sel = f;
         EDGE_BOTH: edge_sel = r | f;
         default: edge_sel = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // input edge detectors
   mct_edge u_cnt_edge (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .sig_i(COUNT_IN_I),
      .rise_o(cnt_rise),
      .fall_o(cnt_fall)
   );

   mct_edge u_cap_edge (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .sig_i(CAPTURE_IN_I),
      .rise_o(cap_rise),
      .fall_o(cap_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   // counting engine
   // counting clock: every cycle, or the selected input edge
   assign tick = (mode_reg == MODE_TIMER) ? 1'b1 :
                 edge_sel(mode_reg, cnt_rise, cnt_fall);
   assign wrap = (precount_reg >= (prescale_reg & width_mask));
   assign advance = ctrl_en_reg & ~ctrl_rst_reg & tick & wrap;
   assign cap_evt = edge_sel(cctl_reg.cap_edge, cap_rise, cap_fall);
   assign clr_evt = cctl_reg.clr_en &
                    edge_sel(cctl_reg.clr_edge, cap_rise, cap_fall);
   assign pwm_mode = |pwm_en_reg;

   // match compare and action qualifiers
   always_comb begin
      for (int i = 0; i < NUM_MATCH; i++) begin
         hit[i] = advance & (count_reg == (match_reg[i] & width_mask));
         stop_hit[i] = hit[i] & mctl_reg[i].stop;
         rst_hit[i] = hit[i] & (mctl_reg[i].reset |
                      (pwm_mode && period_sel_reg == 2'(i)));
      end
   end

   // prescaler next value
   always_comb begin
      precount_next = precount_reg;
      if (ctrl_rst_reg || clr_evt) begin
         precount_next = RST_ZERO;
      end else if (ctrl_en_reg && tick) begin
         precount_next = wrap ? RST_ZERO :
                         ((precount_reg + 32'h1) & width_mask);
      end
   end

   // counter next value
   always_comb begin
      count_next = count_reg;
      if (ctrl_rst_reg || clr_evt) begin
         count_next = RST_ZERO;
      end else if (|rst_hit) begin
         count_next = RST_ZERO;
      end else if (advance) begin
         count_next = (count_reg + 32'h1) & width_mask;
      end
   end

   // counter and prescaler state
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         count_reg <= RST_ZERO;
         precount_reg <= RST_ZERO;
      end else if (req.wr && req.addr == OFS_COUNT) begin
         count_reg <= req.wdata & width_mask;
      end else if (req.wr && req.addr == OFS_PRECOUNT) begin
         precount_reg <= req.wdata & width_mask;
      end else begin
         count_reg <= count_next;
         precount_reg <= precount_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register: stop on match clears the enable
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ctrl_en_reg <= 1'b0;
         ctrl_rst_reg <= 1'b0;
      end else if (|stop_hit) begin
         ctrl_en_reg <= 1'b0;
      end else if (req.wr && req.addr == OFS_CTRL) begin
         ctrl_en_reg <= req.wdata[CTRL_EN_BIT];
         ctrl_rst_reg <= req.wdata[CTRL_RST_BIT];
      end
   end

   // configuration registers
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         prescale_reg <= RST_ZERO;
         cctl_reg <= '0;
         mode_reg <= MODE_TIMER;
         pwm_en_reg <= FLAG_BITS;
         period_sel_reg <= 2'h3;
         for (int i = 0; i < NUM_MATCH; i++) begin
            match_reg[i] <= RST_MATCH;
            mctl_reg[i] <= '0;
            em_act_reg[i] <= EM_NONE;
         end
      end else if (req.wr) begin
         case (req.addr)
            OFS_PRESCALE: prescale_reg <= req.wdata & width_mask;
            OFS_CAPT_CTRL: cctl_reg <= req.wdata[5:0];
            OFS_MODE: mode_reg <= req.wdata[1:0];
            OFS_PWM_CTRL: begin
               pwm_en_reg <= req.wdata[3:0];
               period_sel_reg <= req.wdata[5:4];
            end
            OFS_MATCH_CTRL: begin
               for (int i = 0; i < NUM_MATCH; i++) begin
                  mctl_reg[i] <= req.wdata[3*i +: 3];
               end
            end
            OFS_EXT_MATCH: begin
               for (int i = 0; i < NUM_MATCH; i++) begin
                  em_act_reg[i] <= req.wdata[4 + 2*i +: 2];
               end
            end
            default: begin
               for (int i = 0; i < NUM_MATCH; i++) begin
                  if (req.addr == OFS_MATCH0 + 8'(4*i)) begin
                     match_reg[i] <= req.wdata & width_mask;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // external match levels, also software writable
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         em_lvl_reg <= FLAG_BITS;
      end else begin
         for (int i = 0; i < NUM_MATCH; i++) begin
            if (hit[i]) begin
               case (em_act_reg[i])
                  EM_LOW: em_lvl_reg[i] <= 1'b0;
                  EM_HIGH: em_lvl_reg[i] <= 1'b1;
                  EM_TOGGLE: em_lvl_reg[i] <= ~em_lvl_reg[i];
                  default: em_lvl_reg[i] <= em_lvl_reg[i];
               endcase
            end else if (req.wr && req.addr == OFS_EXT_MATCH) begin
               em_lvl_reg[i] <= req.wdata[i];
            end
         end
      end
   end

   // pwm output stage
   mct_pwm u_pwm (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .enable_i(pwm_en_reg),
      .duty_hit_i(hit),
      .period_hit_i(|rst_hit & pwm_mode),
      .ext_in_i(em_lvl_reg),
      .out_o(MATCH_OUT_O)
   );

   ////////////////////////////////////////////////////////////////////////
   // capture register
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         capture_reg <= RST_ZERO;
      end else if (cap_evt) begin
         capture_reg <= count_reg;
      end
   end

   // sticky flags, write one to clear, set wins over clear
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mflag_reg <= FLAG_BITS;
         cflag_reg <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_MATCH; i++) begin
            if (hit[i] && mctl_reg[i].irq) begin
               mflag_reg[i] <= 1'b1;
            end else if (req.wr && req.addr == OFS_FLAGS && req.wdata[i]) begin
               mflag_reg[i] <= 1'b0;
            end
         end
         if (cap_evt && cctl_reg.irq) begin
            cflag_reg <= 1'b1;
         end else if (req.wr && req.addr == OFS_FLAGS && req.wdata[4]) begin
            cflag_reg <= 1'b0;
         end
      end
   end

   assign MATCH_IRQ_O = mflag_reg;
   assign CAPTURE_IRQ_O = cflag_reg;
   assign ADC_MATCH_TRIG_O = MATCH_OUT_O;
   assign ADC_CAPTURE_TRIG_O = CAPTURE_IN_I;

   ////////////////////////////////////////////////////////////////////////
   // read port, data one cycle after the strobe, zero otherwise
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rdata_reg <= RST_ZERO;
      end else if (req.rd) begin
         case (req.addr)
            OFS_CTRL: rdata_reg <= {30'h0, ctrl_rst_reg, ctrl_en_reg};
            OFS_COUNT: rdata_reg <= count_reg;
            OFS_PRESCALE: rdata_reg <= prescale_reg;
            OFS_PRECOUNT: rdata_reg <= precount_reg;
            OFS_MATCH_CTRL: rdata_reg <= {20'h0, mctl_reg[3], mctl_reg[2],
                                          mctl_reg[1], mctl_reg[0]};
            OFS_CAPT_CTRL: rdata_reg <= {26'h0, cctl_reg};
            OFS_CAPTURE: rdata_reg <= capture_reg;
            OFS_EXT_MATCH: rdata_reg <= {20'h0, em_act_reg[3], em_act_reg[2],
                                         em_act_reg[1], em_act_reg[0],
                                         em_lvl_reg};
            OFS_MODE: rdata_reg <= {30'h0, mode_reg};
            OFS_PWM_CTRL: rdata_reg <= {26'h0, period_sel_reg, pwm_en_reg};
            OFS_FLAGS: rdata_reg <= {27'h0, cflag_reg, mflag_reg};
            OFS_MATCH0: rdata_reg <= match_reg[0];
            OFS_MATCH0 + 8'h04: rdata_reg <= match_reg[1];
            OFS_MATCH0 + 8'h08: rdata_reg <= match_reg[2];
            OFS_MATCH0 + 8'h0C: rdata_reg <= match_reg[3];
            default: rdata_reg <= RST_ZERO;
         endcase
      end else begin
         rdata_reg <= RST_ZERO;
      end
   end

   assign RDATA_O = rdata_reg;
endmodule // mct_timer

/* mct_timer_asserts.sv */
// checker: port-level properties of the match/capture counter/timer
// assumes it is bound to mct_timer and sees only its ports
`timescale 1ns/1ps
module mct_timer_asserts
   import mct_pkg::*;
#(
   parameter bit WIDTH_16 = 1'b0
)
(
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [31:0] RDATA_O,
   input wire logic COUNT_IN_I,
   input wire logic CAPTURE_IN_I,
   input wire logic [NUM_MATCH-1:0] MATCH_OUT_O,
   input wire logic [NUM_MATCH-1:0] MATCH_IRQ_O,
   input wire logic CAPTURE_IRQ_O,
   input wire logic [NUM_MATCH-1:0] ADC_MATCH_TRIG_O,
   input wire logic ADC_CAPTURE_TRIG_O
);
   logic en_reg;
   logic pwm_reg;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   ////////////////////////////////////////////////////////////////////////
   // shadow of the enable and pwm bits as software last wrote them
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         en_reg <= 1'b0;
         pwm_reg <= 1'b0;
      end else if (WR_I && ADDR_I == OFS_CTRL) begin
         en_reg <= WDATA_I[CTRL_EN_BIT];
      end else if (WR_I && ADDR_I == OFS_PWM_CTRL) begin
         pwm_reg <= |WDATA_I[3:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // converter triggers and register port
   a_adc_match_mirror: assert property (
      ADC_MATCH_TRIG_O == MATCH_OUT_O) else $error("match trigger differs");
   a_adc_capt_pass: assert property (
      ADC_CAPTURE_TRIG_O == CAPTURE_IN_I) else $error("capture trigger off");
   a_rdata_quiet: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
      else $error("read data outside read slot");
   a_rdata_unmapped: assert property (
      $past(RD_I) && $past(ADDR_I) >= 8'h40 |-> RDATA_O == 32'h0)
      else $error("unmapped read not zero");
   // flags are sticky until software clears them
   a_irq_sticky: assert property (
      |($past(MATCH_IRQ_O) & ~MATCH_IRQ_O) |->
      $past(WR_I) && $past(ADDR_I) == OFS_FLAGS)
      else $error("match flag dropped without clear");
   a_capt_sticky: assert property (
      $fell(CAPTURE_IRQ_O) |->
      $past(WR_I) && $past(ADDR_I) == OFS_FLAGS && $past(WDATA_I[4]))
      else $error("capture flag dropped without clear");
   a_capt_cause: assert property (
      $rose(CAPTURE_IRQ_O) |-> $past(CAPTURE_IN_I) != $past(CAPTURE_IN_I, 2)
      || $past(CAPTURE_IN_I, 2) != $past(CAPTURE_IN_I, 3))
      else $error("capture flag without input edge");
   // match outputs with the counter idle
   a_ext_write: assert property (
      $past(WR_I) && $past(ADDR_I) == OFS_EXT_MATCH && !$past(en_reg)
      && !$past(pwm_reg) |-> MATCH_OUT_O == $past(WDATA_I[3:0]))
      else $error("match levels not loaded");
   a_idle_quiet: assert property (
      !$past(en_reg) && !$past(en_reg, 2) && !$past(WR_I)
      |-> $stable(MATCH_OUT_O)) else $error("match out moved while idle");
endmodule // mct_timer_asserts

bind mct_timer mct_timer_asserts #(.WIDTH_16(WIDTH_16)) u_asserts (
   .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
   .COUNT_IN_I(COUNT_IN_I), .CAPTURE_IN_I(CAPTURE_IN_I),
   .MATCH_OUT_O(MATCH_OUT_O), .MATCH_IRQ_O(MATCH_IRQ_O),
   .CAPTURE_IRQ_O(CAPTURE_IRQ_O), .ADC_MATCH_TRIG_O(ADC_MATCH_TRIG_O),
   .ADC_CAPTURE_TRIG_O(ADC_CAPTURE_TRIG_O));

/* mct_timer_bench.sv */
// bench: register-port tasks and scenario sequence for the counter/timer
// assumes the pin model on the capture and count inputs
`timescale 1ns/1ps
module mct_timer_bench
   import mct_pkg::*;
;
   logic clk, rst_n, wr, rd, cnt_in, cap_in, cap_irq, adc_cap;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] mout, mirq, adc_m;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [31:0] em_set [3] = '{{22'h0, EM_LOW, 8'h04},
      {22'h0, EM_HIGH, 8'h00}, {22'h0, EM_NONE, 8'h04}};
   logic em_exp [3] = '{1'b0, 1'b1, 1'b1};
   mct_timer dut (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .COUNT_IN_I(cnt_in), .CAPTURE_IN_I(cap_in), .MATCH_OUT_O(mout),
      .MATCH_IRQ_O(mirq), .CAPTURE_IRQ_O(cap_irq),
      .ADC_MATCH_TRIG_O(adc_m), .ADC_CAPTURE_TRIG_O(adc_cap));
   mct_pins_model u_pins (.clk_i(clk), .match_i(mout), .capture_o(cap_in),
      .count_o(cnt_in));
   ////////////////////////////////////////////////////////////////////////
   // 125 MHz clock and hang guard
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // register port and compare tasks
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic check_cnt(input int got, input int exp);
      tests_run++;
      if (got != exp) begin
         fail_count++;
         $display("wrong value at %0t: count %0d want %0d", $time, got, exp);
      end
   endtask
   task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
      check_val(d, exp);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // reset values, unmapped place
      for (int i = 0; i < 4; i++) begin
         check_reg(OFS_MATCH0 + 8'(4 * i), RST_MATCH);
      end
      check_reg(OFS_PWM_CTRL, 32'h30);
      wr_reg(8'h40, 32'hFFFF_FFFF);
      check_reg(8'h40, 32'h0);
      // prescale 3: nine advances in 37 cycles, then stop one past match
      wr_reg(OFS_PRESCALE, 32'h3);
      wr_reg(OFS_CTRL, 32'h1);
      repeat (36) @(posedge clk);
      check_reg(OFS_COUNT, 32'h9);
      wr_reg(OFS_MATCH0, 32'hC);
      wr_reg(OFS_MATCH_CTRL, 32'h5);
      repeat (40) @(posedge clk);
      check_reg(OFS_COUNT, 32'hD);
      check_reg(OFS_CTRL, 32'h0);
      check_val({31'h0, mirq[0]}, 32'h1);
      check_reg(OFS_FLAGS, 32'h1);
      wr_reg(OFS_FLAGS, 32'h1F);
      check_val({28'h0, mirq}, 32'h0);
      // match 1 resets every fourth cycle and toggles output 1
      wr_reg(OFS_CTRL, 32'h2);
      wr_reg(OFS_PRESCALE, 32'h0);
      wr_reg(OFS_MATCH0 + 8'h4, 32'h3);
      wr_reg(OFS_MATCH_CTRL, 32'h10);
      wr_reg(OFS_EXT_MATCH, {24'h0, EM_TOGGLE, 6'h00});
      wr_reg(OFS_CTRL, 32'h1);
      u_pins.measure(40);
      check_cnt(u_pins.tog[1], 10);
      check_val({28'h0, mirq}, 32'h0);
      // low, high and hold actions on output 2
      wr_reg(OFS_MATCH0 + 8'h8, 32'h1);
      for (int i = 0; i < 3; i++) begin
         wr_reg(OFS_CTRL, 32'h2);
         wr_reg(OFS_EXT_MATCH, em_set[i]);
         wr_reg(OFS_CTRL, 32'h1);
         repeat (12) @(posedge clk);
         check_val({31'h0, mout[2]}, {31'h0, em_exp[i]});
         check_val({31'h0, adc_m[2]}, {31'h0, em_exp[i]});
      end
      // clear on rising capture edge, capture on falling edge
      wr_reg(OFS_CTRL, 32'h2);
      wr_reg(OFS_MATCH_CTRL, 32'h0);
      wr_reg(OFS_CAPT_CTRL, 32'h2E);
      wr_reg(OFS_CTRL, 32'h1);
      // converter trigger follows the capture pin while it is high
      fork
         u_pins.pulse(20);
         begin
            repeat (2) @(posedge clk);
            check_val({31'h0, adc_cap}, 32'h1);
         end
      join
      repeat (3) @(posedge clk);
      check_reg(OFS_CAPTURE, 32'h13);
      check_val({31'h0, cap_irq}, 32'h1);
      wr_reg(OFS_FLAGS, 32'h10);
      check_val({31'h0, cap_irq}, 32'h0);
      // count mode on rising, falling and both edges of five pulses
      wr_reg(OFS_CAPT_CTRL, 32'h0);
      for (int m = 1; m < 4; m++) begin
         wr_reg(OFS_CTRL, 32'h2);
         wr_reg(OFS_MODE, 32'(m));
         wr_reg(OFS_CTRL, 32'h1);
         u_pins.count_pulses(5);
         repeat (3) @(posedge clk);
         check_reg(OFS_COUNT, (m == 3) ? 32'hA : 32'h5);
      end
      // pwm on outputs 0 and 1, period of ten from match 3
      wr_reg(OFS_CTRL, 32'h2);
      wr_reg(OFS_MODE, 32'h0);
      wr_reg(OFS_MATCH0, 32'h2);
      wr_reg(OFS_MATCH0 + 8'h4, 32'h5);
      wr_reg(OFS_MATCH0 + 8'hC, 32'h9);
      wr_reg(OFS_PWM_CTRL, 32'h33);
      wr_reg(OFS_CTRL, 32'h1);
      repeat (25) @(posedge clk);
      u_pins.measure(100);
      check_cnt(u_pins.high[0], 70);
      check_cnt(u_pins.high[1], 40);
      conclude();
   end
endmodule // mct_timer_bench
